// ---- src/gate_regs_params.svh ----
// register addresses, field positions and defaults for the gate driver register bank
`ifndef GATE_REGS_PARAMS_SVH
`define GATE_REGS_PARAMS_SVH

`define REG_W            11
`define ADDR_W           4
`define WORD_W           16
`define ADDR_WARN        4'h1
`define ADDR_OCUR        4'h2
`define ADDR_CHIP        4'h3
`define ADDR_GATE        4'h4
`define ADDR_HS_DRV      4'h5
`define ADDR_LS_DRV      4'h6
`define ADDR_TIMING      4'h7
`define ADDR_RSVD        4'h8
`define ADDR_OPER        4'h9
`define ADDR_AMP         4'hA
`define ADDR_REGUL       4'hB
`define ADDR_DS_SENSE    4'hC
`define CTRL_FIRST       4'h5
`define CTRL_COUNT       8
`define RW_BIT           15
`define ADDR_HI          14
`define ADDR_LO          11
`define STATUS_RESET     11'h000
`define WD_EN_BIT        3
`define WDOG_MS          10
`define WDOG_CYCLES      (`WDOG_MS * 250000)

`endif

// ---- src/gate_regs_pkg.sv ----
// types shared by the gate driver register bank
package gate_regs_pkg;
    typedef logic [10:0] reg_word_type;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10
    } access_type;
endpackage : gate_regs_pkg

// ---- src/ctrl_reg_slot.sv ----
// one read/write control register with default-on-sleep
`timescale 1ns/1ps
`include "gate_regs_params.svh"

module ctrl_reg_slot #(
    parameter logic [10:0] DEFAULT_VAL = 11'h000
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        sleep_i,
    input  wire logic        wr_en_i,
    input  wire logic [10:0] wr_data_i,
    output logic      [10:0] value_o
);
    // reset and sleep both restore the default
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || sleep_i) begin
            value_o <= DEFAULT_VAL;
        end else if (wr_en_i) begin
            value_o <= wr_data_i;
        end
    end
endmodule : ctrl_reg_slot

// ---- src/gate_status_regs.sv ----
// register bank of the three-phase gate driver
// Function
// - status registers 0x1-0x4 ignore writes
// - warning register access restarts watchdog
// - general fault bit10, overheat warning bit0
// - heat flags at bits 3,2,1,8
// - supply low bit7, supply high bit6
// - bit5 is live OR of overcurrents
// - pump low warning in bit4
// - per-transistor overcurrent bits 10 to 5
// - amplifier overcurrent bits 2..0, 4:3 reserved
// - lockout, watchdog, shutdown bits 10,9,8
// - regulator bit6, analog supply bit5
// - low-side supply bit4, 7 and 3 reserved
// - pump faults in bits 2,1,0
// - gate faults bits 10..5, 4:0 reserved
// - answer returns addressed register contents
// - sleep restores control register defaults
`timescale 1ns/1ps
`include "gate_regs_params.svh"

module gate_status_regs #(
    parameter int          WDOG_CYCLES = `WDOG_CYCLES,
    parameter logic [10:0] HS_DEFAULT  = 11'h344,
    parameter logic [10:0] LS_DEFAULT  = 11'h344,
    parameter logic [10:0] TIM_DEFAULT = 11'h000,
    parameter logic [10:0] OP_DEFAULT  = 11'h000,
    parameter logic [10:0] AMP_DEFAULT = 11'h000,
    parameter logic [10:0] REG_DEFAULT = 11'h000,
    parameter logic [10:0] DS_DEFAULT  = 11'h000
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        word_valid_i,
    input  wire logic [15:0] word_i,
    input  wire logic        sleep_i,
    input  wire logic        overheat_warning_i,
    input  wire logic        heat_flag_105_i,
    input  wire logic        heat_flag_125_i,
    input  wire logic        heat_flag_135_i,
    input  wire logic        heat_flag_175_i,
    input  wire logic        main_supply_low_warning_i,
    input  wire logic        main_supply_high_warning_i,
    input  wire logic        pump_low_warning_i,
    input  wire logic [5:0]  overcurrent_live_i,
    input  wire logic [2:0]  amp_overcurrent_i,
    input  wire logic        main_supply_lockout_fault_i,
    input  wire logic        overheat_shutdown_fault_i,
    input  wire logic        regulator_low_fault_i,
    input  wire logic        analog_supply_low_fault_i,
    input  wire logic        low_side_supply_fault_i,
    input  wire logic        pump_low_fault_i,
    input  wire logic        pump_high_fault_i,
    input  wire logic        pump_absolute_high_fault_i,
    input  wire logic [5:0]  gate_fault_i,
    output logic             resp_valid_o,
    output logic      [15:0] resp_word_o,
    output logic             watchdog_kick_o,
    output logic             watchdog_expired_fault_o,
    output logic      [10:0] high_side_drive_strength_o,
    output logic      [10:0] low_side_drive_strength_o,
    output logic      [10:0] drive_timing_control_o,
    output logic      [10:0] chip_operation_control_o,
    output logic      [10:0] current_amp_control_o,
    output logic      [10:0] regulator_control_o,
    output logic      [10:0] drain_source_sense_control_o
);
    // ==============================================================
    // command decode
    logic                      is_read;
    logic [3:0]                cmd_addr;
    logic [10:0]               cmd_data;
    gate_regs_pkg::access_type access_kind;
    logic [10:0]               ctrl_val [`CTRL_COUNT];
    logic [`CTRL_COUNT-1:0]    ctrl_wr;

    assign is_read  = word_i[`RW_BIT];
    assign cmd_addr = word_i[`ADDR_HI:`ADDR_LO];
    assign cmd_data = word_i[`REG_W-1:0];

    // classify the incoming command
    always_comb begin
        if (!word_valid_i) begin
            access_kind = gate_regs_pkg::ST_IDLE;
        end else if (is_read) begin
            access_kind = gate_regs_pkg::ST_READ;
        end else begin
            access_kind = gate_regs_pkg::ST_WRITE;
        end
    end

    // ==============================================================
    // status words, assembled live from the monitors
    gate_regs_pkg::reg_word_type warn_word;
    gate_regs_pkg::reg_word_type ocur_word;
    gate_regs_pkg::reg_word_type chip_word;
    gate_regs_pkg::reg_word_type gate_word;
    logic                        any_fault;

    assign any_fault = |{ocur_word, chip_word, gate_word};
    assign warn_word = {any_fault, 1'b0, heat_flag_175_i,
                        main_supply_low_warning_i,
                        main_supply_high_warning_i,
                        |overcurrent_live_i,
                        pump_low_warning_i,
                        heat_flag_105_i, heat_flag_125_i,
                        heat_flag_135_i, overheat_warning_i};
    assign ocur_word = {overcurrent_live_i, 2'b00, amp_overcurrent_i};
    assign chip_word = {main_supply_lockout_fault_i,
                        watchdog_expired_fault_o,
                        overheat_shutdown_fault_i, 1'b0,
                        regulator_low_fault_i,
                        analog_supply_low_fault_i,
                        low_side_supply_fault_i, 1'b0,
                        pump_low_fault_i, pump_high_fault_i,
                        pump_absolute_high_fault_i};
    assign gate_word = {gate_fault_i, 5'b00000};

    // ==============================================================
    // control registers, one slot per address 0x5..0xC
    genvar g;
    generate
        for (g = 0; g < `CTRL_COUNT; g++) begin : g_ctrl
            localparam logic [3:0] SLOT_ADDR = `CTRL_FIRST + 4'(g);
            localparam logic [10:0] DEF =
                (g == 0) ? HS_DEFAULT  : (g == 1) ? LS_DEFAULT :
                (g == 2) ? TIM_DEFAULT : (g == 4) ? OP_DEFAULT :
                (g == 5) ? AMP_DEFAULT : (g == 6) ? REG_DEFAULT :
                (g == 7) ? DS_DEFAULT  : 11'h000;
            // the reserved slot at 0x8 never accepts a write
            assign ctrl_wr[g] = (access_kind == gate_regs_pkg::ST_WRITE)
                                && (cmd_addr == SLOT_ADDR)
                                && (SLOT_ADDR != `ADDR_RSVD);
            ctrl_reg_slot #(
                .DEFAULT_VAL (DEF)
            ) u_slot (
                .clk_i     (clk_i),
                .sys_rst_i (sys_rst_i),
                .sleep_i   (sleep_i),
                .wr_en_i   (ctrl_wr[g]),
                .wr_data_i (cmd_data),
                .value_o   (ctrl_val[g])
            );
        end
    endgenerate

    assign high_side_drive_strength_o   = ctrl_val[0];
    assign low_side_drive_strength_o    = ctrl_val[1];
    assign drive_timing_control_o       = ctrl_val[2];
    assign chip_operation_control_o     = ctrl_val[4];
    assign current_amp_control_o        = ctrl_val[5];
    assign regulator_control_o          = ctrl_val[6];
    assign drain_source_sense_control_o = ctrl_val[7];

    // ==============================================================
    // read multiplexer: contents before any write of this command
    gate_regs_pkg::reg_word_type read_val;
    always_comb begin
        unique case (cmd_addr)
            `ADDR_WARN:     read_val = warn_word;
            `ADDR_OCUR:     read_val = ocur_word;
            `ADDR_CHIP:     read_val = chip_word;
            `ADDR_GATE:     read_val = gate_word;
            `ADDR_HS_DRV:   read_val = ctrl_val[0];
            `ADDR_LS_DRV:   read_val = ctrl_val[1];
            `ADDR_TIMING:   read_val = ctrl_val[2];
            `ADDR_OPER:     read_val = ctrl_val[4];
            `ADDR_AMP:      read_val = ctrl_val[5];
            `ADDR_REGUL:    read_val = ctrl_val[6];
            `ADDR_DS_SENSE: read_val = ctrl_val[7];
            default:        read_val = `STATUS_RESET;
        endcase
    end

    // response word for reads and writes alike; status addresses take no write
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            resp_valid_o <= 1'b0;
            resp_word_o  <= 16'h0000;
        end else begin
            resp_valid_o <= word_valid_i;
            if (word_valid_i) begin
                resp_word_o <= {5'b00000, read_val};
            end
        end
    end

    // ==============================================================
    // watchdog: any access to the warning register restarts it
    logic [31:0] wdog_cnt_reg;
    logic        wdog_en;
    assign wdog_en         = ctrl_val[4][`WD_EN_BIT];
    assign watchdog_kick_o = word_valid_i && (cmd_addr == `ADDR_WARN);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || sleep_i || !wdog_en || watchdog_kick_o) begin
            wdog_cnt_reg <= 32'h00000000;
        end else if (wdog_cnt_reg < 32'(WDOG_CYCLES)) begin
            wdog_cnt_reg <= wdog_cnt_reg + 32'h00000001;
        end
    end

    // expiry flag; held until reset or sleep, an expiry in the sleep cycle wins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            watchdog_expired_fault_o <= 1'b0;
        end else if (wdog_en && wdog_cnt_reg == 32'(WDOG_CYCLES) - 32'h00000001) begin
            watchdog_expired_fault_o <= 1'b1;
        end else if (sleep_i) begin
            watchdog_expired_fault_o <= 1'b0;
        end
    end

    // ==============================================================
    // checks
    // a valid command aimed at one status address
    sequence warn_access_s;
        word_valid_i && cmd_addr == `ADDR_WARN;
    endsequence
    sequence ocur_access_s;
        word_valid_i && cmd_addr == `ADDR_OCUR;
    endsequence
    sequence chip_access_s;
        word_valid_i && cmd_addr == `ADDR_CHIP;
    endsequence
    sequence gate_access_s;
        word_valid_i && cmd_addr == `ADDR_GATE;
    endsequence

    // last counted cycle before the watchdog runs out
    sequence wdog_last_s;
        wdog_en && wdog_cnt_reg == 32'(WDOG_CYCLES) - 32'h00000001;
    endsequence

    status_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        word_valid_i && !is_read && cmd_addr <= `ADDR_GATE && cmd_addr != 4'h0
        |-> ctrl_wr == '0)
        else $error("write to status register changed state");

    kick_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        watchdog_kick_o |=> wdog_cnt_reg == 32'h00000000)
        else $error("watchdog not restarted by access");

    live_or_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        warn_access_s
        |=> resp_word_o[5] == |$past(overcurrent_live_i))
        else $error("live overcurrent bit wrong");

    resp_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        word_valid_i |=> resp_valid_o && resp_word_o[10:0] == $past(read_val))
        else $error("response does not carry register contents");

    reserved_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ocur_word[4:3] == 2'b00 && chip_word[7] == 1'b0 && chip_word[3] == 1'b0
        && gate_word[4:0] == 5'b00000 && warn_word[9] == 1'b0)
        else $error("reserved bit not zero");

    sleep_default_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sleep_i |=> high_side_drive_strength_o == HS_DEFAULT
        && low_side_drive_strength_o == LS_DEFAULT && drive_timing_control_o == TIM_DEFAULT
        && chip_operation_control_o == OP_DEFAULT && current_amp_control_o == AMP_DEFAULT
        && regulator_control_o == REG_DEFAULT
        && drain_source_sense_control_o == DS_DEFAULT)
        else $error("control register not defaulted on sleep");

    fault_bit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        warn_word[10] == (|{overcurrent_live_i, amp_overcurrent_i, gate_fault_i,
                            main_supply_lockout_fault_i, watchdog_expired_fault_o,
                            overheat_shutdown_fault_i, regulator_low_fault_i,
                            analog_supply_low_fault_i, low_side_supply_fault_i,
                            pump_low_fault_i, pump_high_fault_i,
                            pump_absolute_high_fault_i}))
        else $error("general fault bit wrong");

    pump_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        chip_word[2:0] == {pump_low_fault_i, pump_high_fault_i, pump_absolute_high_fault_i})
        else $error("pump fault mapping wrong");

    heat_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        warn_access_s |=> resp_word_o[8] == $past(heat_flag_175_i)
        && resp_word_o[3] == $past(heat_flag_105_i)
        && resp_word_o[2] == $past(heat_flag_125_i)
        && resp_word_o[1] == $past(heat_flag_135_i)
        && resp_word_o[0] == $past(overheat_warning_i))
        else $error("heat flag mapping wrong");

    supply_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        warn_access_s |=> resp_word_o[7] == $past(main_supply_low_warning_i)
        && resp_word_o[6] == $past(main_supply_high_warning_i)
        && resp_word_o[4] == $past(pump_low_warning_i) && resp_word_o[9] == 1'b0)
        else $error("supply warning mapping wrong");

    ocur_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ocur_access_s |=> resp_word_o[10:5] == $past(overcurrent_live_i)
        && resp_word_o[4:3] == 2'b00 && resp_word_o[2:0] == $past(amp_overcurrent_i))
        else $error("overcurrent fault mapping wrong");

    chip_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        chip_access_s |=> resp_word_o[10] == $past(main_supply_lockout_fault_i)
        && resp_word_o[9] == $past(watchdog_expired_fault_o)
        && resp_word_o[8] == $past(overheat_shutdown_fault_i) && resp_word_o[7] == 1'b0
        && resp_word_o[6] == $past(regulator_low_fault_i)
        && resp_word_o[5] == $past(analog_supply_low_fault_i)
        && resp_word_o[4] == $past(low_side_supply_fault_i) && resp_word_o[3] == 1'b0)
        else $error("chip fault mapping wrong");

    gate_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gate_access_s |=> resp_word_o[10:5] == $past(gate_fault_i)
        && resp_word_o[4:0] == 5'h00)
        else $error("gate fault mapping wrong");

    expiry_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wdog_last_s |=> watchdog_expired_fault_o)
        else $error("watchdog expiry not flagged");

    fault_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        watchdog_expired_fault_o && !sleep_i |=> watchdog_expired_fault_o)
        else $error("watchdog fault dropped without sleep");
endmodule : gate_status_regs

// ---- tb/reg_host_model.sv ----
// controller model that issues register frames to the gate driver register bank
`timescale 1ns/1ps

module reg_host_model (
    input  wire logic        clk_i,
    input  wire logic        resp_valid_i,
    input  wire logic [15:0] resp_word_i,
    input  wire logic        kick_i,
    output logic             word_valid_o,
    output logic      [15:0] word_o
);
    // =========================================
    // frame issue
    initial begin
        word_valid_o = 1'b0;
        word_o       = 16'hFFFF;
    end

    // one frame per call; released word lines show the inverse of the last frame
    task automatic xfer(input logic rd, input logic [3:0] adr, input logic [10:0] dat,
                        output logic [15:0] resp, output logic vld, output logic kick);
        @(posedge clk_i);
        word_valid_o <= 1'b1;
        word_o       <= {rd, adr, dat};
        #1 kick = kick_i;
        @(posedge clk_i);
        word_valid_o <= 1'b0;
        word_o       <= ~{rd, adr, dat};
        #1 vld = resp_valid_i;
        resp = resp_word_i;
    endtask : xfer
endmodule : reg_host_model

// ---- tb/testbench.sv ----
// self-checking bench of the gate driver register bank
`timescale 1ns/1ps

module testbench;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        sleep_i = 1'b0;
    logic [30:0] mon = '0;
    logic        word_valid, resp_valid, kick, watchdog_expired_fault;
    logic [15:0] word, resp_word;
    logic [10:0] hs_o, ls_o, tim_o, op_o, amp_o, reg_o, ds_o;
    logic [10:0] ctl [16];
    logic        wd_exp = 1'b0;
    int          err_total = 0;
    int          n_checks = 0;
    int          cycles = 0;

    // =========================================
    // clock, timeout and instances
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end

    reg_host_model reg_host_model_i (.clk_i(clk_i), .resp_valid_i(resp_valid),
        .resp_word_i(resp_word), .kick_i(kick), .word_valid_o(word_valid), .word_o(word));

    gate_status_regs #(.WDOG_CYCLES(20)) gate_status_regs_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .word_valid_i(word_valid), .word_i(word),
        .sleep_i(sleep_i), .overheat_warning_i(mon[0]), .heat_flag_105_i(mon[1]),
        .heat_flag_125_i(mon[2]), .heat_flag_135_i(mon[3]), .heat_flag_175_i(mon[4]),
        .main_supply_low_warning_i(mon[5]), .main_supply_high_warning_i(mon[6]),
        .pump_low_warning_i(mon[7]), .overcurrent_live_i(mon[13:8]),
        .amp_overcurrent_i(mon[16:14]), .main_supply_lockout_fault_i(mon[17]),
        .overheat_shutdown_fault_i(mon[18]), .regulator_low_fault_i(mon[19]),
        .analog_supply_low_fault_i(mon[20]), .low_side_supply_fault_i(mon[21]),
        .pump_low_fault_i(mon[22]), .pump_high_fault_i(mon[23]),
        .pump_absolute_high_fault_i(mon[24]), .gate_fault_i(mon[30:25]),
        .resp_valid_o(resp_valid), .resp_word_o(resp_word), .watchdog_kick_o(kick),
        .watchdog_expired_fault_o(watchdog_expired_fault), .high_side_drive_strength_o(hs_o),
        .low_side_drive_strength_o(ls_o), .drive_timing_control_o(tim_o),
        .chip_operation_control_o(op_o), .current_amp_control_o(amp_o),
        .regulator_control_o(reg_o), .drain_source_sense_control_o(ds_o));

    // =========================================
    // expected register contents
    function automatic logic [10:0] exp_read(input logic [3:0] a);
        logic [10:0] oc, ch, gt;
        oc = {mon[13:8], 2'b00, mon[16:14]};
        ch = {mon[17], wd_exp, mon[18], 1'b0, mon[19], mon[20], mon[21], 1'b0, mon[24:22]};
        ch[2:0] = {mon[22], mon[23], mon[24]};
        gt = {mon[30:25], 5'h00};
        case (a)
            4'h1: exp_read = {|{oc, ch, gt}, 1'b0, mon[4], mon[5], mon[6], |mon[13:8],
                              mon[7], mon[1], mon[2], mon[3], mon[0]};
            4'h2: exp_read = oc;
            4'h3: exp_read = ch;
            4'h4: exp_read = gt;
            4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC: exp_read = ctl[a];
            default: exp_read = 11'h000;
        endcase
    endfunction : exp_read

    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    // one access with response, kick and control port checks
    task automatic acc(input logic rd, input logic [3:0] a, input logic [10:0] d);
        logic [15:0] r;
        logic        v, k;
        reg_host_model_i.xfer(rd, a, d, r, v, k);
        chk("kick", {79'h0, a == 4'h1}, {79'h0, k});
        chk("resp valid", 80'h1, {79'h0, v});
        chk("resp word", {69'h0, exp_read(a)}, {64'h0, r});
        if (!rd && a inside {[4'h5:4'h7], [4'h9:4'hC]})
            ctl[a] = d;
        chk("controls", {3'b0, ctl[5], ctl[6], ctl[7], ctl[9], ctl[10], ctl[11], ctl[12]},
            {3'b0, hs_o, ls_o, tim_o, op_o, amp_o, reg_o, ds_o});
        chk("watchdog_expired_fault", {79'h0, wd_exp}, {79'h0, watchdog_expired_fault});
    endtask : acc

    task automatic defaults();
        foreach (ctl[i])
            ctl[i] = 11'h000;
        ctl[5] = 11'h344;
        ctl[6] = 11'h344;
    endtask : defaults

    task automatic complete_run();
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // =========================================
    // main sequence
    initial begin
        logic [3:0]  a;
        logic [10:0] d;
        void'($urandom(32'h2FDB));
        defaults();
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 16; i++)
            acc(1'b1, i[3:0], 11'h000);
        @(posedge clk_i);
        mon <= '1;
        for (int i = 1; i < 5; i++) begin
            acc(1'b0, i[3:0], 11'h7FF);
            acc(1'b1, i[3:0], 11'h000);
        end
        for (int n = 0; n < 300; n++) begin
            @(posedge clk_i);
            mon <= 31'($urandom);
            a = 4'($urandom);
            d = 11'($urandom);
            if (a == 4'h9)
                d = d & 11'h0E0;
            acc(1'($urandom), a, d);
        end
        acc(1'b0, 4'h9, 11'h008);
        for (int n = 0; n < 8; n++) begin
            repeat (8) @(posedge clk_i);
            acc(1'b1, 4'h1, 11'h000);
        end
        repeat (40) @(posedge clk_i);
        wd_exp = 1'b1;
        acc(1'b1, 4'h3, 11'h000);
        acc(1'b1, 4'h1, 11'h000);
        @(posedge clk_i);
        sleep_i <= 1'b1;
        @(posedge clk_i);
        sleep_i <= 1'b0;
        wd_exp = 1'b0;
        defaults();
        for (int i = 0; i < 16; i++)
            acc(1'b1, i[3:0], 11'h000);
        complete_run();
    end
endmodule : testbench
